//--- inc/flash_host_defines.svh
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
// ==========================================================
// Register offsets
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_DATA 12'h008
`define REG_STATUS 12'h00C
`define REG_RDATA 12'h010
// ==========================================================
// Control fields
`define CTRL_GO_BIT 0
`define CTRL_CMD_LSB 4
`define CTRL_BYTE_BIT 8
// ==========================================================
// Command codes
`define CODE_UNLOCK1 16'h00AA
`define CODE_UNLOCK2 16'h0055
`define CODE_PROGRAM 16'h00A0
`define CODE_ERASE_SETUP 16'h0080
`define CODE_CHIP_ERASE 16'h0010
`define CODE_SECTOR_ERASE 16'h0030
`define CODE_RESUME 16'h0030
`define CODE_SUSPEND 16'h00B0
`define CODE_RESET 16'h00F0
`define CODE_IDENT 16'h0090
`define WORD_UNLOCK_A 20'h00555
`define WORD_UNLOCK_B 20'h002AA
`define BYTE_UNLOCK_A 20'h00AAA
`define BYTE_UNLOCK_B 20'h00555
// ==========================================================
// Bus timing
`define STROBE_NS 100
`define STROBE_CYC ((`STROBE_NS + 49) / 50)
`endif

//--- inc/flash_host_pkg.sv
package flash_host_pkg;
    typedef enum logic [3:0] {
        OP_RESET, OP_READ, OP_IDENT, OP_PROGRAM, OP_CHIP_ERASE,
        OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_POLL
    } op_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_POLL, ST_NEXT
    } state_e;
endpackage

//--- rtl/flash_host.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.svh"

module flash_host
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output logic [ADDR_W-1:0] flash_addr,
    output logic chip_sel_n,
    output logic write_en_n,
    output logic out_en_n,
    output logic byte_mode_n,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic [15:0] data_in,
    input wire logic ready_busy_out
);
    import flash_host_pkg::*;

    // ==========================================================
    // Input synchronisers, three stages
    logic [16:0] sync1, sync2, sync3, pin_val;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_val <= '0;
        end else if (clk_en) begin
            sync1 <= {ready_busy_out, data_in};
            sync2 <= sync1;
            sync3 <= sync2;
            // Change counts once two late stages agree
            for (int i = 0; i < 17; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_val[i] <= sync3[i];
                end
            end
        end
    end

    // ==========================================================
    // Sequence table
    function automatic logic [35:0] step_of(input op_e op, input logic [2:0] idx,
                                            input logic bm, input logic [ADDR_W-1:0] a,
                                            input logic [15:0] d);
        logic [ADDR_W-1:0] ua, ub;
        logic [35:0] r;
        ua = bm ? ADDR_W'(`BYTE_UNLOCK_A) : ADDR_W'(`WORD_UNLOCK_A);
        ub = bm ? ADDR_W'(`BYTE_UNLOCK_B) : ADDR_W'(`WORD_UNLOCK_B);
        r = {ADDR_W'(0), 16'h0000};
        case (idx)
            3'd0: r = {ua, 16'(`CODE_UNLOCK1)};
            3'd1: r = {ub, 16'(`CODE_UNLOCK2)};
            3'd2: r = {ua, (op == OP_PROGRAM) ? 16'(`CODE_PROGRAM) :
                       (op == OP_IDENT) ? 16'(`CODE_IDENT) : 16'(`CODE_ERASE_SETUP)};
            3'd3: r = (op == OP_PROGRAM) ? {a, d} : {ua, 16'(`CODE_UNLOCK1)};
            3'd4: r = {ub, 16'(`CODE_UNLOCK2)};
            default: r = (op == OP_CHIP_ERASE) ? {ua, 16'(`CODE_CHIP_ERASE)}
                                               : {a, 16'(`CODE_SECTOR_ERASE)};
        endcase
        return r;
    endfunction

    function automatic logic [2:0] len_of(input op_e op);
        case (op)
            OP_PROGRAM: return 3'd4;
            OP_CHIP_ERASE: return 3'd6;
            OP_SECTOR_ERASE: return 3'd6;
            OP_IDENT: return 3'd3;
            default: return 3'd1;
        endcase
    endfunction

    // ==========================================================
    // Controller state
    state_e state, next_state;
    op_e op, next_op;
    logic [2:0] idx, next_idx;
    logic [3:0] cnt, next_cnt;
    logic busy, next_busy;
    logic fail, next_fail;
    logic byte_sel, next_byte_sel;
    logic [ADDR_W-1:0] arg_addr, next_arg_addr;
    logic [15:0] arg_data, next_arg_data;
    logic [15:0] rdata, next_rdata;
    logic [15:0] last_poll, next_last_poll;
    logic [ADDR_W-1:0] next_flash_addr;
    logic next_cs_n, next_we_n, next_oe_n, next_data_oe;
    logic [15:0] next_data_out;
    logic [31:0] next_prdata;
    logic next_pready;
    logic wr_go;

    assign wr_go = psel && penable && pready && pwrite && paddr == `REG_CTRL &&
                   pwdata[`CTRL_GO_BIT] && !busy;

    always_comb begin
        logic [35:0] st;
        st = step_of(op, idx, byte_sel, arg_addr, arg_data);
        next_state = state;
        next_op = op;
        next_idx = idx;
        next_cnt = cnt;
        next_busy = busy;
        next_fail = fail;
        next_byte_sel = byte_sel;
        next_arg_addr = arg_addr;
        next_arg_data = arg_data;
        next_rdata = rdata;
        next_last_poll = last_poll;
        next_flash_addr = flash_addr;
        next_cs_n = chip_sel_n;
        next_we_n = write_en_n;
        next_oe_n = out_en_n;
        next_data_oe = data_oe;
        next_data_out = data_out;
        next_pready = 1'b0;
        next_prdata = prdata;
        // APB register access, no wait states
        if (psel && !penable) begin
            next_pready = 1'b1;
            case (paddr)
                `REG_ADDR: next_prdata = 32'(arg_addr);
                `REG_DATA: next_prdata = {16'h0000, arg_data};
                `REG_STATUS: next_prdata = {29'h0, pin_val[16], fail, busy};
                `REG_RDATA: next_prdata = {16'h0000, rdata};
                `REG_CTRL: next_prdata = {23'h0, byte_sel, 4'(op), 4'h0};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        // Writes land in the access cycle that carries pready
        if (psel && penable && pready && pwrite && !busy) begin
            if (paddr == `REG_ADDR) next_arg_addr = pwdata[ADDR_W-1:0];
            if (paddr == `REG_DATA) next_arg_data = pwdata[15:0];
        end
        if (wr_go) begin
            next_op = op_e'(pwdata[`CTRL_CMD_LSB +: 4]);
            next_byte_sel = pwdata[`CTRL_BYTE_BIT];
            next_busy = 1'b1;
            next_fail = 1'b0;
            next_idx = 3'd0;
            next_state = ST_SETUP;
        end
        case (state)
            ST_IDLE: ;
            ST_SETUP: begin
                next_cs_n = 1'b0;
                next_cnt = 4'(`STROBE_CYC);
                if (op == OP_READ || op == OP_POLL) begin
                    next_flash_addr = arg_addr;
                    next_oe_n = 1'b0;
                    next_data_oe = 1'b0;
                end else begin
                    // upper bits left zero on unlock writes
                    if (op == OP_RESET || op == OP_SUSPEND || op == OP_RESUME) begin
                        next_flash_addr = '0;
                        next_data_out = (op == OP_RESET) ? 16'(`CODE_RESET) :
                                        (op == OP_SUSPEND) ? 16'(`CODE_SUSPEND) :
                                        16'(`CODE_RESUME);
                    end else begin
                        next_flash_addr = st[35:16];
                        next_data_out = st[15:0];
                    end
                    next_we_n = 1'b0;
                    next_data_oe = 1'b1;
                end
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt > 4'd1) begin
                    next_cnt = cnt - 4'd1;
                end else begin
                    next_we_n = 1'b1;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Sync delay before sampling pins
                if (cnt < 4'd4) begin
                    next_cnt = cnt + 4'd1;
                end else begin
                    // Read enable held until the synchroniser has settled
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_data_oe = 1'b0;
                    next_cnt = 4'd0;
                    next_state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (op == OP_READ || op == OP_POLL) begin
                    next_rdata = pin_val[15:0];
                end
                if (idx + 3'd1 < len_of(op)) begin
                    next_idx = idx + 3'd1;
                    next_state = ST_SETUP;
                end else if (op == OP_PROGRAM || op == OP_CHIP_ERASE ||
                             op == OP_SECTOR_ERASE || op == OP_RESUME) begin
                    // poll until the device is done
                    next_op = OP_POLL;
                    next_idx = 3'd0;
                    next_last_poll = ~pin_val[15:0];
                    next_state = ST_SETUP;
                end else if (op == OP_POLL) begin
                    // done once the toggle bit stands still and bit 7 matches the data
                    if (pin_val[6] == last_poll[6] && pin_val[7] == arg_data[7]) begin
                        next_busy = 1'b0;
                        next_state = ST_IDLE;
                    // timeout bit ends the wait as failure
                    end else if (pin_val[5] && pin_val[6] != last_poll[6]) begin
                        next_fail = 1'b1;
                        next_busy = 1'b0;
                        next_state = ST_IDLE;
                    end else begin
                        next_last_poll = pin_val[15:0];
                        next_state = ST_SETUP;
                    end
                end else begin
                    next_busy = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            op <= OP_RESET;
            idx <= 3'd0;
            cnt <= 4'd0;
            busy <= 1'b0;
            fail <= 1'b0;
            byte_sel <= 1'b0;
            arg_addr <= '0;
            arg_data <= 16'h0000;
            rdata <= 16'h0000;
            last_poll <= 16'h0000;
            flash_addr <= '0;
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
            out_en_n <= 1'b1;
            byte_mode_n <= 1'b1;
            data_out <= 16'h0000;
            data_oe <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            op <= next_op;
            idx <= next_idx;
            cnt <= next_cnt;
            busy <= next_busy;
            fail <= next_fail;
            byte_sel <= next_byte_sel;
            arg_addr <= next_arg_addr;
            arg_data <= next_arg_data;
            rdata <= next_rdata;
            last_poll <= next_last_poll;
            flash_addr <= next_flash_addr;
            chip_sel_n <= next_cs_n;
            write_en_n <= next_we_n;
            out_en_n <= next_oe_n;
            byte_mode_n <= !next_byte_sel;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- sim/flash_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host_sva #(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Flash pins
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic chip_sel_n,
    input wire logic write_en_n,
    input wire logic out_en_n,
    input wire logic [15:0] data_out,
    input wire logic data_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);
    // ==========================================
    // Bus access
    sequence we_pulse;
        !write_en_n [*2] ##1 write_en_n;
    endsequence
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    apb_single_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready outside a single access cycle");
    no_error_a: assert property (pslverr == 1'b0)
        else $error("error response raised");
    // ==========================================
    // Flash strobes
    // strobe width
    we_width_a: assert property ($fell(write_en_n) |-> we_pulse)
        else $error("write strobe width wrong");
    we_in_cs_a: assert property (!write_en_n |-> !chip_sel_n)
        else $error("write strobe without chip select");
    addr_hold_a: assert property (!write_en_n && !$past(write_en_n) |->
        $stable(flash_addr) && $stable(data_out))
        else $error("address or data moved under strobe");
    data_at_rise_a: assert property ($rose(write_en_n) |-> !chip_sel_n && data_oe)
        else $error("data or select gone at strobe rise");
    // Avoids bus contention
    no_contention_a: assert property (data_oe |-> out_en_n)
        else $error("host drives data while output enabled");
    read_no_write_a: assert property (!out_en_n |-> write_en_n)
        else $error("read and write strobes together");
endmodule
bind flash_host flash_host_sva #(.ADDR_W(ADDR_W)) chk (
    .pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
    .flash_addr, .chip_sel_n, .write_en_n, .out_en_n, .data_out, .data_oe);
`default_nettype wire

//--- sim/flash_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter int PROG_CYC = 40,
    parameter int ERASE_CYC = 300,
    // Arbitrary identifier values
    parameter logic [15:0] MAKER_ID = 16'h005A,
    parameter logic [15:0] DEV_ID = 16'h1234
) (
    // Timing and fault control
    input wire logic pclk,
    input wire logic fail_en,
    // Flash pins
    input wire logic [19:0] flash_addr,
    input wire logic chip_sel_n,
    input wire logic write_en_n,
    input wire logic out_en_n,
    input wire logic byte_mode_n,
    input wire logic [15:0] data_out,
    output logic [15:0] data_in,
    output logic ready_busy_out
);
    logic [15:0] mem [0:255];
    logic [19:0] wa;
    logic [15:0] last = 16'h0000;
    logic [11:0] am, u1, u2;
    logic [7:0] ix;
    logic [5:0] sec;
    logic pd7 = 1'b0, tog = 1'b0, f5 = 1'b0, idm = 1'b0;
    int cnt = 0, seq = 0;
    wire wr_act = !chip_sel_n && !write_en_n;
    wire rd_en = !chip_sel_n && !out_en_n;
    wire [7:0] rix = byte_mode_n ? flash_addr[7:0] : flash_addr[8:1];
    wire [1:0] sel = byte_mode_n ? flash_addr[1:0] : flash_addr[2:1];
    wire [15:0] lane = (flash_addr[0] && !byte_mode_n) ? {8'h00, mem[rix][15:8]} :
        byte_mode_n ? mem[rix] : {8'h00, mem[rix][7:0]};
    wire [15:0] rv = (cnt > 0) ? {8'h00, ~pd7, tog, f5, 5'h00} :
        idm ? (sel[1] ? 16'h0000 : sel[0] ? DEV_ID : MAKER_ID) : lane;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
    // Released bus shows inverse
    assign data_in = rd_en ? rv : ~last;
    assign ready_busy_out = (cnt == 0);
    always @(posedge pclk) begin
        if (cnt > 0 && !f5) cnt = cnt - 1;
        if (rd_en) last <= rv;
    end
    always @(posedge out_en_n) if (cnt > 0) tog = ~tog;
    always @(posedge wr_act) wa = flash_addr;
    always @(negedge wr_act) begin
        u1 = byte_mode_n ? 12'h555 : 12'hAAA;
        u2 = byte_mode_n ? 12'h2AA : 12'h555;
        am = byte_mode_n ? {1'b0, wa[10:0]} : wa[11:0];
        ix = byte_mode_n ? wa[7:0] : wa[8:1];
        sec = byte_mode_n ? wa[18:13] : wa[19:14];
        if (cnt > 0) begin
            if (f5 && data_out[7:0] == 8'hF0) begin
                cnt = 0;
                f5 = 1'b0;
            end
        end else if (data_out[7:0] == 8'hF0) begin
            seq = 0;
            idm = 1'b0;
        end else case (seq)
            0: seq = (am == u1 && data_out[7:0] == 8'hAA) ? 1 : 0;
            1: seq = (am == u2 && data_out[7:0] == 8'h55) ? 2 : 0;
            2: begin
                seq = 0;
                if (am == u1 && data_out[7:0] == 8'hA0) seq = 3;
                if (am == u1 && data_out[7:0] == 8'h80) seq = 4;
                if (am == u1 && data_out[7:0] == 8'h90) idm = 1'b1;
            end
            3: begin
                if (byte_mode_n) mem[ix] = data_out;
                else if (wa[0]) mem[ix][15:8] = data_out[7:0];
                else mem[ix][7:0] = data_out[7:0];
                pd7 = data_out[7];
                cnt = PROG_CYC;
                seq = 0;
            end
            4: seq = (am == u1 && data_out[7:0] == 8'hAA) ? 5 : 0;
            5: seq = (am == u2 && data_out[7:0] == 8'h55) ? 6 : 0;
            default: begin
                seq = 0;
                if ((am == u1 && data_out[7:0] == 8'h10) || data_out[7:0] == 8'h30) begin
                    // modelled array lies in the lowest sector
                    if (data_out[7:0] == 8'h10 || sec == 6'h00) begin
                        for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
                    end
                    pd7 = 1'b1;
                    cnt = ERASE_CYC;
                    f5 = fail_en;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

//--- sim/tb_flash_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_defines.svh"
module tb_flash_host;
    import flash_host_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic fail_en = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, chip_sel_n, write_en_n, out_en_n, byte_mode_n, data_oe, rb;
    logic [19:0] flash_addr;
    logic [15:0] data_out, data_in;
    int bad_count = 0, n_compared = 0;
    always #25 pclk = ~pclk;
    flash_host uut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .flash_addr, .chip_sel_n, .write_en_n,
        .out_en_n, .byte_mode_n, .data_out, .data_oe, .data_in, .ready_busy_out(rb));
    flash_dev_model dev (.pclk, .fail_en, .flash_addr, .chip_sel_n, .write_en_n,
        .out_en_n, .byte_mode_n, .data_out, .data_in, .ready_busy_out(rb));
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            end_sim();
        end
    endtask
    task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d,
        input logic bm);
        int n;
        n = 0;
        apb(1'b1, `REG_ADDR, {12'h000, a});
        apb(1'b1, `REG_DATA, {16'h0000, d});
        apb(1'b1, `REG_CTRL, {23'h0, bm, op, 3'h0, 1'b1});
        do begin
            apb(1'b0, `REG_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            bad_count++;
            end_sim();
        end
    endtask
    task automatic read_word(input logic [19:0] a, input logic bm);
        run(4'h1, a, 16'h0000, bm);
        apb(1'b0, `REG_RDATA, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h00000004);
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        apb(1'b0, 12'h020, 32'h0);
        check(rd, 32'h00000000);
        // Busy must refuse a second order
        apb(1'b1, `REG_ADDR, 32'h00012);
        apb(1'b1, `REG_DATA, 32'h5A3C);
        apb(1'b1, `REG_CTRL, 32'h31);
        apb(1'b0, `REG_STATUS, 32'h0);
        check({31'h0, rd[0]}, 32'h1);
        apb(1'b1, `REG_DATA, 32'h1111);
        apb(1'b1, `REG_CTRL, 32'h31);
        run(4'h1, 20'h00012, 16'h0000, 1'b1);
        check({16'h0, dev.mem[8'h12]}, 32'h5A3C);
        apb(1'b0, `REG_RDATA, 32'h0);
        check(rd, 32'h5A3C);
        run(4'h2, 20'h00000, 16'h0000, 1'b1);
        read_word(20'h00000, 1'b1);
        check(rd, {16'h0, dev.MAKER_ID});
        read_word(20'h00002, 1'b1);
        check(rd, {16'h0, dev.DEV_ID});
        read_word(20'h00004, 1'b1);
        check(rd, 32'h00000000);
        run(4'h0, 20'h00000, 16'h0000, 1'b1);
        read_word(20'h00012, 1'b0);
        check(rd, 32'h5A3C);
        run(4'h3, 20'h00081, 16'h0077, 1'b1);
        read_word(20'h00081, 1'b1);
        check({24'h0, rd[7:0]}, 32'h77);
        check({16'h0, dev.mem[8'h40]}, 32'h77FF);
        run(4'h5, 20'h00000, 16'h00FF, 1'b1);
        read_word(20'h00012, 1'b0);
        check(rd, 32'hFFFF);
        run(4'h3, 20'h00030, 16'h0F0F, 1'b1);
        check({16'h0, dev.mem[8'h18]}, 32'hFF0F);
        run(4'h4, 20'h00000, 16'h00FF, 1'b1);
        read_word(20'h00030, 1'b1);
        check(rd, 32'h00FF);
        fail_en <= 1'b1;
        run(4'h5, 20'h00000, 16'h00FF, 1'b1);
        check({31'h0, rd[1]}, 32'h1);
        fail_en <= 1'b0;
        run(4'h0, 20'h00000, 16'h0000, 1'b1);
        run(4'h3, 20'h00050, 16'hABCD, 1'b0);
        read_word(20'h00050, 1'b0);
        check(rd, 32'hABCD);
        // Erase of a far sector leaves the low array alone
        run(4'h5, 20'h08000, 16'h00FF, 1'b0);
        read_word(20'h00050, 1'b0);
        check(rd, 32'hABCD);
        run(4'h6, 20'h00000, 16'h0000, 1'b0);
        run(4'h7, 20'h00050, 16'hABCD, 1'b0);
        read_word(20'h00050, 1'b0);
        check(rd, 32'hABCD);
        end_sim();
    end
endmodule
`default_nettype wire
